/* hw/analog_ctl.sv */
// analog subsystem control: converter sequencing, dac registers, comparators, interrupts
`timescale 1ns/1ps
module analog_ctl #(
  parameter int CONV_MC = analog_ctl_pkg::CONV_CYCLES,
  parameter int MC_CLKS = analog_ctl_pkg::CLKS_PER_MC,
  parameter int RC_CLKS = analog_ctl_pkg::RC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [analog_ctl_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [analog_ctl_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [analog_ctl_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic rc_tick,
  input wire logic [7:0] conv_sample,
  input wire logic [1:0] cmp_a_gt,
  input wire logic [1:0] cmp_b_gt,
  output logic [1:0] conv_channel,
  output logic conv_sampling,
  output logic dac_a_drive,
  output logic dac_b_drive,
  output logic [7:0] dac_a_code,
  output logic [7:0] dac_b_code,
  output logic cmp_a_pin,
  output logic cmp_a_pin_oe_b,
  output logic cmp_b_pin,
  output logic cmp_b_pin_oe_b,
  output logic cmp_a_pos_sel,
  output logic cmp_b_pos_sel,
  output logic cpu_idle,
  output logic cpu_power_down,
  output logic cpu_wake,
  output logic irq
);
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CONV_CPU_CNT = CNT_W'(CONV_MC * MC_CLKS);
  localparam logic [CNT_W-1:0] CONV_RC_CNT = CNT_W'(RC_CLKS);
  // value left in dac a after an aborted conversion; software must not trust it
  localparam logic [7:0] RESET_INVALID = analog_ctl_pkg::RESET_DAC;

  analog_ctl_pkg::conv_ctrl_s conv, next_conv;
  analog_ctl_pkg::cmp_ctrl_s cmp_a, cmp_b, next_cmp_a, next_cmp_b;
  analog_ctl_pkg::conv_state_e state, next_state;
  logic [CNT_W-1:0] count, next_count;
  logic [7:0] dac_a, dac_b, next_dac_a, next_dac_b;
  logic idle_mode, down_mode, next_idle_mode, next_down_mode;
  logic [analog_ctl_pkg::IRQ_W-1:0] status, mask, next_status, next_mask;
  logic [analog_ctl_pkg::DATA_W-1:0] next_readdata;
  logic next_waitrequest;
  logic next_wake;
  logic cmp_a_res, cmp_b_res, cmp_a_chg, cmp_b_chg;
  logic wr_hit, rd_hit, done_evt;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic be);
    merge_byte = be ? new_v : old_v;
  endfunction : merge_byte

  function automatic logic [7:0] cmp_byte(input analog_ctl_pkg::cmp_ctrl_s c,
                                          input logic res);
    logic [7:0] v;
    v = 8'h00;
    v[analog_ctl_pkg::CM_FLAG] = c.cmp_change_flag;
    v[analog_ctl_pkg::CM_OUT] = res;
    v[analog_ctl_pkg::CM_OE] = c.cmp_pin_output_enable;
    v[analog_ctl_pkg::CM_NEG] = c.neg_input_select;
    v[analog_ctl_pkg::CM_POS] = c.pos_input_select;
    v[analog_ctl_pkg::CM_EN] = c.enable;
    cmp_byte = v;
  endfunction : cmp_byte

  function automatic analog_ctl_pkg::cmp_ctrl_s cmp_write(input analog_ctl_pkg::cmp_ctrl_s c,
                                                          input logic [7:0] v,
                                                          input logic chg);
    analog_ctl_pkg::cmp_ctrl_s r;
    r.enable = v[analog_ctl_pkg::CM_EN];
    r.pos_input_select = v[analog_ctl_pkg::CM_POS];
    r.neg_input_select = v[analog_ctl_pkg::CM_NEG];
    r.cmp_pin_output_enable = v[analog_ctl_pkg::CM_OE];
    // a change in the same cycle wins over a software clear
    r.cmp_change_flag = (c.cmp_change_flag & v[analog_ctl_pkg::CM_FLAG]) | chg;
    cmp_write = r;
  endfunction : cmp_write

  comparator_ctl u_cmp_a (
    .clk(clk),
    .rst_b(rst_b),
    .enable(cmp_a.enable),
    .pos_input_select(cmp_a.pos_input_select),
    .neg_input_select(cmp_a.neg_input_select),
    .pos_gt_neg(cmp_a_gt),
    .result(cmp_a_res),
    .change(cmp_a_chg)
  );

  comparator_ctl u_cmp_b (
    .clk(clk),
    .rst_b(rst_b),
    .enable(cmp_b.enable),
    .pos_input_select(cmp_b.pos_input_select),
    .neg_input_select(cmp_b.neg_input_select),
    .pos_gt_neg(cmp_b_gt),
    .result(cmp_b_res),
    .change(cmp_b_chg)
  );

  // one wait cycle per access: read data are captured at the taking edge,
  // writes land only at the edge where the master sees waitrequest low
  assign wr_hit = write & !waitrequest;
  assign rd_hit = read & waitrequest;

  always_comb begin
    next_waitrequest = 1'b1;
    if ((read | write) && waitrequest) begin
      next_waitrequest = 1'b0;
    end
  end

  // converter sequencing
  always_comb begin
    next_state = state;
    next_count = count;
    done_evt = 1'b0;
    unique case (state)
      analog_ctl_pkg::CONV_IDLE: begin
        if (conv.conv_start_bit) begin
          next_state = analog_ctl_pkg::CONV_RUN;
          next_count = conv.rc_conv_clock_select ? CONV_RC_CNT : CONV_CPU_CNT;
        end
      end
      analog_ctl_pkg::CONV_RUN: begin
        if (down_mode && !conv.rc_conv_clock_select) begin
          next_state = analog_ctl_pkg::CONV_IDLE;  // R05
        end else if (!conv.rc_conv_clock_select || rc_tick) begin  // R04
          if (count == CNT_W'(1)) begin
            next_state = analog_ctl_pkg::CONV_IDLE;
            done_evt = 1'b1;  // R01
          end else begin
            next_count = count - CNT_W'(1);
          end
        end
      end
    endcase
  end

  // register updates
  always_comb begin
    next_conv = conv;
    next_dac_a = dac_a;
    next_dac_b = dac_b;
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    next_idle_mode = idle_mode;
    next_down_mode = down_mode;
    next_mask = mask;
    next_status = status;
    next_wake = 1'b0;
    if (wr_hit && byteenable[0]) begin
      unique case (address)
        analog_ctl_pkg::OFF_CONV_CTRL: begin
          // channel and clock choice are frozen while a conversion runs
          if (!conv.conv_start_bit) begin
            next_conv.chan = writedata[analog_ctl_pkg::CC_CHAN_LO +: 2];
            next_conv.rc_conv_clock_select = writedata[analog_ctl_pkg::CC_RC_SEL];
            next_conv.conv_start_bit = writedata[analog_ctl_pkg::CC_START]
                                       & !conv.conv_done_flag;
          end
          if (!conv.conv_start_bit && !conv.conv_done_flag) begin
            next_conv.dac_a_enable = writedata[analog_ctl_pkg::CC_DAC_A_EN];
          end
          next_conv.conv_done_flag = conv.conv_done_flag & writedata[analog_ctl_pkg::CC_DONE];
          next_conv.dac_b_enable = writedata[analog_ctl_pkg::CC_DAC_B_EN];
          next_conv.conv_enable = writedata[analog_ctl_pkg::CC_CONV_EN];
        end
        analog_ctl_pkg::OFF_DAC_A: next_dac_a = merge_byte(dac_a, writedata[7:0], 1'b1);
        analog_ctl_pkg::OFF_DAC_B: next_dac_b = merge_byte(dac_b, writedata[7:0], 1'b1);
        analog_ctl_pkg::OFF_CMP_A: next_cmp_a = cmp_write(cmp_a, writedata[7:0], 1'b0);
        analog_ctl_pkg::OFF_CMP_B: next_cmp_b = cmp_write(cmp_b, writedata[7:0], 1'b0);
        analog_ctl_pkg::OFF_POWER: begin
          next_idle_mode = writedata[analog_ctl_pkg::PW_IDLE];
          next_down_mode = writedata[analog_ctl_pkg::PW_DOWN];
        end
        analog_ctl_pkg::OFF_IRQ_MASK: next_mask = writedata[analog_ctl_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (rd_hit && address == analog_ctl_pkg::OFF_IRQ_STATUS) begin
      next_status = '0;
    end
    if (state == analog_ctl_pkg::CONV_RUN && down_mode && !conv.rc_conv_clock_select) begin
      next_conv.conv_start_bit = 1'b0;
      next_dac_a = RESET_INVALID;  // R05
    end
    if (done_evt) begin
      next_dac_a = conv_sample;  // R09
      next_conv.conv_start_bit = 1'b0;
      next_conv.conv_done_flag = 1'b1;  // R09
      next_status[analog_ctl_pkg::IRQ_CONV] = 1'b1;
      if (mask[analog_ctl_pkg::IRQ_CONV] && !conv.rc_conv_clock_select) begin
        next_idle_mode = 1'b0;  // R03
        next_wake = 1'b1;  // R03
      end else if (mask[analog_ctl_pkg::IRQ_CONV]) begin
        next_idle_mode = 1'b0;
        next_down_mode = 1'b0;
        next_wake = 1'b1;
      end
    end
    if (cmp_a_chg) begin
      next_cmp_a.cmp_change_flag = 1'b1;  // R16
      next_status[analog_ctl_pkg::IRQ_CMP_A] = 1'b1;  // R15
    end
    if (cmp_b_chg) begin
      next_cmp_b.cmp_change_flag = 1'b1;  // R16
      next_status[analog_ctl_pkg::IRQ_CMP_B] = 1'b1;  // R15
    end
    if ((cmp_a_chg && mask[analog_ctl_pkg::IRQ_CMP_A])
        || (cmp_b_chg && mask[analog_ctl_pkg::IRQ_CMP_B])) begin
      next_idle_mode = 1'b0;
      next_down_mode = 1'b0;
      next_wake = 1'b1;
    end
  end

  always_comb begin
    next_readdata = '0;
    if (rd_hit) begin
      unique case (address)
        analog_ctl_pkg::OFF_CONV_CTRL: begin
          next_readdata[analog_ctl_pkg::CC_CHAN_LO +: 2] = conv.chan;
          next_readdata[analog_ctl_pkg::CC_RC_SEL] = conv.rc_conv_clock_select;
          next_readdata[analog_ctl_pkg::CC_START] = conv.conv_start_bit;
          next_readdata[analog_ctl_pkg::CC_DONE] = conv.conv_done_flag;
          next_readdata[analog_ctl_pkg::CC_DAC_A_EN] = conv.dac_a_enable;
          next_readdata[analog_ctl_pkg::CC_DAC_B_EN] = conv.dac_b_enable;
          next_readdata[analog_ctl_pkg::CC_CONV_EN] = conv.conv_enable;
        end
        analog_ctl_pkg::OFF_DAC_A: next_readdata[7:0] = dac_a;
        analog_ctl_pkg::OFF_DAC_B: next_readdata[7:0] = dac_b;
        analog_ctl_pkg::OFF_CMP_A: next_readdata[7:0] = cmp_byte(cmp_a, cmp_a_res);
        analog_ctl_pkg::OFF_CMP_B: next_readdata[7:0] = cmp_byte(cmp_b, cmp_b_res);
        analog_ctl_pkg::OFF_POWER: begin
          next_readdata[analog_ctl_pkg::PW_IDLE] = idle_mode;
          next_readdata[analog_ctl_pkg::PW_DOWN] = down_mode;
        end
        analog_ctl_pkg::OFF_IRQ_STATUS: next_readdata[analog_ctl_pkg::IRQ_W-1:0] = status;
        analog_ctl_pkg::OFF_IRQ_MASK: next_readdata[analog_ctl_pkg::IRQ_W-1:0] = mask;
        default: next_readdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv <= analog_ctl_pkg::conv_ctrl_s'(analog_ctl_pkg::RESET_CONV_CTRL);
      cmp_a <= analog_ctl_pkg::cmp_ctrl_s'(analog_ctl_pkg::RESET_CMP[4:0]);
      cmp_b <= analog_ctl_pkg::cmp_ctrl_s'(analog_ctl_pkg::RESET_CMP[4:0]);
      state <= analog_ctl_pkg::CONV_IDLE;
      count <= '0;
      dac_a <= analog_ctl_pkg::RESET_DAC;
      dac_b <= analog_ctl_pkg::RESET_DAC;
      idle_mode <= 1'b0;
      down_mode <= 1'b0;
      status <= '0;
      mask <= '0;
      readdata <= '0;
      waitrequest <= 1'b1;
      cpu_wake <= 1'b0;
    end else begin
      conv <= next_conv;
      cmp_a <= next_cmp_a;
      cmp_b <= next_cmp_b;
      state <= next_state;
      count <= next_count;
      dac_a <= next_dac_a;
      dac_b <= next_dac_b;
      idle_mode <= next_idle_mode;
      down_mode <= next_down_mode;
      status <= next_status;
      mask <= next_mask;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      cpu_wake <= next_wake;
    end
  end

  // pin-facing outputs, all registered one cycle behind the control state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_channel <= 2'h0;
      conv_sampling <= 1'b0;
      dac_a_drive <= 1'b0;
      dac_b_drive <= 1'b0;
      dac_a_code <= analog_ctl_pkg::RESET_DAC;
      dac_b_code <= analog_ctl_pkg::RESET_DAC;
      cmp_a_pin <= 1'b0;
      cmp_a_pin_oe_b <= 1'b1;
      cmp_b_pin <= 1'b0;
      cmp_b_pin_oe_b <= 1'b1;
      cmp_a_pos_sel <= 1'b0;
      cmp_b_pos_sel <= 1'b0;
      cpu_idle <= 1'b0;
      cpu_power_down <= 1'b0;
      irq <= 1'b0;
    end else begin
      conv_channel <= conv.chan;
      conv_sampling <= state == analog_ctl_pkg::CONV_RUN;
      dac_a_drive <= conv.dac_a_enable;  // R11
      dac_b_drive <= conv.dac_b_enable;
      dac_a_code <= dac_a;  // R12
      dac_b_code <= dac_b;  // R12
      cmp_a_pin <= cmp_a_res;  // R14
      cmp_a_pin_oe_b <= !(cmp_a.enable & cmp_a.cmp_pin_output_enable);  // R17
      cmp_b_pin <= cmp_b_res;  // R14
      cmp_b_pin_oe_b <= !(cmp_b.enable & cmp_b.cmp_pin_output_enable);  // R17
      cmp_a_pos_sel <= cmp_a.pos_input_select;  // R17
      cmp_b_pos_sel <= cmp_b.pos_input_select;  // R17
      cpu_idle <= idle_mode;
      cpu_power_down <= down_mode;
      irq <= |(status & mask);
    end
  end
endmodule : analog_ctl

/* hw/analog_ctl_pkg.sv */
// package: register map, field layout and timing constants of the analog control block
// Overview of operation
// R01: with cpu clock the conversion completes 31 machine cycles after start
// R02: software never picks rc clock for converter above a 4 MHz cpu clock
// R03: completion with interrupt active ends idle mode and resumes the cpu
// R04: rc-clocked conversion keeps running during power down
// R05: power down with cpu clock aborts conversion, no wake, result invalid
// R06: software enters idle or power down within two cycles of start
// R07: software merges channel, sets start, waits done flag, reads result, clears flag
// R08: software clears channel field by masking control with 0xFC
// R09: on completion result loads dac a register and done flag sets together
// R10: two 8-bit dac channels; software keeps dac a off while converting
// R11: dac a drives an output from its register when enabled
// R12: dac codes are unsigned; level is (code + 0.5) * span / 256
// R13: software disables digital drivers on enabled dac pins
// R14: comparator output is one when positive input exceeds negative input
// R15: each comparator may raise an interrupt on every output change; the code raises none when disabling forces the output to zero
// R16: each comparator sets its change flag on every output change; the code sets none when disabling forces the output to zero
// R17: identical comparator controls: pos select, neg select, pin output enable
// R18: software waits 10 us after comparator enable before trusting it
// R19: software clears change flag before enabling comparator interrupt
package analog_ctl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // word indices; byte address is four times these
  localparam logic [ADDR_W-1:0] OFF_CONV_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_DAC_A = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_DAC_B = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_CMP_A = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_CMP_B = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_POWER = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h7;
  // converter control bit positions
  localparam int CC_CHAN_LO = 0;
  localparam int CC_RC_SEL = 2;
  localparam int CC_START = 3;
  localparam int CC_DONE = 4;
  localparam int CC_DAC_A_EN = 5;
  localparam int CC_DAC_B_EN = 6;
  localparam int CC_CONV_EN = 7;
  // comparator control bit positions
  localparam int CM_FLAG = 0;
  localparam int CM_OUT = 1;
  localparam int CM_OE = 2;
  localparam int CM_NEG = 3;
  localparam int CM_POS = 4;
  localparam int CM_EN = 5;
  // power control bit positions
  localparam int PW_IDLE = 0;
  localparam int PW_DOWN = 1;
  // interrupt bits
  localparam int IRQ_CONV = 0;
  localparam int IRQ_CMP_A = 1;
  localparam int IRQ_CMP_B = 2;
  localparam int IRQ_W = 3;
  localparam int CONV_CYCLES = 31;
  localparam int CLKS_PER_MC = 6;
  localparam int RC_CYCLES = 110;
  localparam logic [7:0] RESET_DAC = 8'h00;
  localparam logic [7:0] RESET_CMP = 8'h00;
  localparam logic [7:0] RESET_CONV_CTRL = 8'h00;
  typedef struct packed {
    logic [1:0] chan;
    logic rc_conv_clock_select;
    logic conv_start_bit;
    logic conv_done_flag;
    logic dac_a_enable;
    logic dac_b_enable;
    logic conv_enable;
  } conv_ctrl_s;
  typedef struct packed {
    logic enable;
    logic pos_input_select;
    logic neg_input_select;
    logic cmp_pin_output_enable;
    logic cmp_change_flag;
  } cmp_ctrl_s;
  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN} conv_state_e;
endpackage : analog_ctl_pkg

/* hw/comparator_ctl.sv */
// one comparator: input routing, result register and change detection
`timescale 1ns/1ps
module comparator_ctl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic pos_input_select,
  input wire logic neg_input_select,
  input wire logic [1:0] pos_gt_neg,
  output logic result,
  output logic change
);
  logic raw;
  logic next_result;
  logic next_change;
  // pos_gt_neg[i] is the analog decision for negative source i with the selected positive pin
  always_comb begin
    raw = enable & pos_gt_neg[neg_input_select];  // R14
    next_result = raw;
    next_change = enable & (raw != result);  // R16
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 1'b0;
      change <= 1'b0;
    end else begin
      result <= next_result;
      change <= next_change;
    end
  end
endmodule : comparator_ctl

/* dv/analog_ctl_chk.sv */
// checker: port-level timing properties of the analog control block
`timescale 1ns/1ps
module analog_ctl_chk #(
  parameter int CONV_MC = 31,
  parameter int MC_CLKS = 6,
  parameter int RC_CLKS = 110
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [analog_ctl_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [analog_ctl_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] cmp_a_gt,
  input wire logic [1:0] cmp_b_gt,
  input wire logic [1:0] conv_channel,
  input wire logic conv_sampling,
  input wire logic cmp_a_pin,
  input wire logic cmp_a_pin_oe_b,
  input wire logic cmp_b_pin,
  input wire logic cmp_b_pin_oe_b,
  input wire logic cpu_idle,
  input wire logic cpu_wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence taken_s;
    (read || write) && waitrequest;
  endsequence
  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence
  // result counted only once the pin has been driven long enough to settle
  property cmp_p(logic oe_b, logic [1:0] gt, logic pin, logic v);
    (!oe_b && $past(!oe_b) && $past(!oe_b, 2) && $past(gt) == {2{v}} && $past(gt, 2) == {2{v}})
      |-> pin == v;
  endproperty
  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("bus answer not one wait cycle");
  read_idle_a: assert property (waitrequest |-> readdata == '0)
    else $error("readdata nonzero outside answer");
  chan_hold_a: assert property (conv_sampling && $past(conv_sampling) |-> $stable(conv_channel))
    else $error("channel moved during conversion");
  cmp_a_one_a: assert property (cmp_p(cmp_a_pin_oe_b, cmp_a_gt, cmp_a_pin, 1'b1))
    else $error("comparator a not one");
  cmp_a_zero_a: assert property (cmp_p(cmp_a_pin_oe_b, cmp_a_gt, cmp_a_pin, 1'b0))
    else $error("comparator a not zero");
  cmp_b_one_a: assert property (cmp_p(cmp_b_pin_oe_b, cmp_b_gt, cmp_b_pin, 1'b1))
    else $error("comparator b not one");
  cmp_b_zero_a: assert property (cmp_p(cmp_b_pin_oe_b, cmp_b_gt, cmp_b_pin, 1'b0))
    else $error("comparator b not zero");
  wake_pulse_a: assert property (cpu_wake |=> !cpu_wake)
    else $error("wake longer than one cycle");
  wake_idle_a: assert property (cpu_wake |-> ##[0:1] !cpu_idle)
    else $error("idle not ended by wake");
endmodule : analog_ctl_chk
bind analog_ctl analog_ctl_chk #(.CONV_MC(CONV_MC), .MC_CLKS(MC_CLKS), .RC_CLKS(RC_CLKS)) chk_u (
  .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .cmp_a_gt(cmp_a_gt), .cmp_b_gt(cmp_b_gt),
  .conv_channel(conv_channel), .conv_sampling(conv_sampling), .cmp_a_pin(cmp_a_pin),
  .cmp_a_pin_oe_b(cmp_a_pin_oe_b), .cmp_b_pin(cmp_b_pin), .cmp_b_pin_oe_b(cmp_b_pin_oe_b),
  .cpu_idle(cpu_idle), .cpu_wake(cpu_wake));

/* dv/tb.sv */
// self-checking bench for the analog control block
`timescale 1ns/1ps
module tb;
  localparam int RC_N = 8;
  localparam int CONV_T = analog_ctl_pkg::CONV_CYCLES * analog_ctl_pkg::CLKS_PER_MC;
  logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, rc_tick = 1'b0, rc_on = 1'b0;
  logic [3:0] address = 4'h0, byteenable = 4'h0;
  logic [31:0] writedata = 32'h0, q, readdata;
  logic [7:0] conv_sample = 8'h00, dac_a_code, dac_b_code, smp;
  logic [1:0] cmp_a_gt = 2'h0, cmp_b_gt = 2'h0, conv_channel, g, pin, oeb, psel;
  logic waitrequest, conv_sampling, dac_a_drive, dac_b_drive, cmp_a_pin, cmp_a_pin_oe_b;
  logic cmp_b_pin, cmp_b_pin_oe_b, cmp_a_pos_sel, cmp_b_pos_sel, cpu_idle, cpu_power_down;
  logic cpu_wake, irq;
  integer seed = 32'h9bd282ae;
  int miscompares = 0, total_checks = 0, cyc = 0, ticks = 0, wakes = 0, t0, w0, cfg;
  int mreg[8];
  assign pin = {cmp_b_pin, cmp_a_pin};
  assign oeb = {cmp_b_pin_oe_b, cmp_a_pin_oe_b};
  assign psel = {cmp_b_pos_sel, cmp_a_pos_sel};
  analog_ctl #(.RC_CLKS(RC_N)) dut_u (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .rc_tick(rc_tick), .conv_sample(conv_sample),
    .cmp_a_gt(cmp_a_gt), .cmp_b_gt(cmp_b_gt), .conv_channel(conv_channel),
    .conv_sampling(conv_sampling), .dac_a_drive(dac_a_drive), .dac_b_drive(dac_b_drive),
    .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .cmp_a_pin(cmp_a_pin),
    .cmp_a_pin_oe_b(cmp_a_pin_oe_b), .cmp_b_pin(cmp_b_pin), .cmp_b_pin_oe_b(cmp_b_pin_oe_b),
    .cmp_a_pos_sel(cmp_a_pos_sel), .cmp_b_pos_sel(cmp_b_pos_sel), .cpu_idle(cpu_idle),
    .cpu_power_down(cpu_power_down), .cpu_wake(cpu_wake), .irq(irq));
  always #4 clk = ~clk;
  // rc clock modelled as a slow tick train, only while a test asks for it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rc_tick <= rc_on && (cyc % 3 == 0);
    if (rc_on && (cyc % 3 == 0)) ticks <= ticks + 1;
    if (cpu_wake === 1'b1) wakes <= wakes + 1;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    // waitrequest and readdata are registers: right after the edge they show the sampled values
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk("bus timeout", 32'h0, 32'h1);
      conclude();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hF);
    if (a == 4'h1 || a == 4'h2 || a == 4'h7) mreg[a] = d;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("reg %0d", a), e, q & m);
  endtask : rd
  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (n >= bound) begin
      chk("irq wait", 32'h1, 32'h0);
      conclude();
    end
  endtask : wait_irq
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 9; a++) rd(a[3:0], 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, $random(seed));
      wr(4'h2, $random(seed));
      bus(1'b1, 4'h2, 32'h0000_00A5, 4'hE);
      rd(4'h1, mreg[1], 32'hFF);
      rd(4'h2, mreg[2], 32'hFF);
      chk("dac a code", mreg[1], {24'h0, dac_a_code});
      chk("dac b code", mreg[2], {24'h0, dac_b_code});
    end
    wr(4'h0, 8'h60);
    cycles(2);
    chk("dac drives", 32'h3, {30'h0, dac_b_drive, dac_a_drive});
    wr(4'h0, 8'h80);
    $display("test dac done");
    smp = $random(seed);
    conv_sample <= smp;
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h8A);
    t0 = cyc;
    w0 = wakes;
    wr(4'h5, 8'h01);
    chk("channel", 32'h2, {30'h0, conv_channel});
    wait_irq(400);
    chk("conv time ok", 32'h1, {31'h0, (cyc - t0 >= CONV_T - 2) && (cyc - t0 <= CONV_T + 6)});
    chk("result", {24'h0, smp}, {24'h0, dac_a_code});
    cycles(2);
    chk("wake count", 32'h1, wakes - w0);
    chk("idle ended", 32'h0, {31'h0, cpu_idle});
    rd(4'h0, 32'h92, 32'hFF);
    wr(4'h0, 8'h9A);
    rd(4'h0, 32'h92, 32'hFF);
    rd(4'h6, 32'h1, 32'hFF);
    cycles(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(4'h6, 32'h0, 32'hFF);
    wr(4'h0, 8'h80);
    rd(4'h0, 32'h80, 32'hFF);
    $display("test cpu clock conversion done");
    smp = $random(seed);
    conv_sample <= smp;
    wr(4'h0, 8'h8D);
    t0 = ticks;
    rc_on <= 1'b1;
    wr(4'h5, 8'h02);
    wait_irq(400);
    rc_on <= 1'b0;
    chk("rc ticks ok", 32'h1, {31'h0, (ticks - t0 >= RC_N) && (ticks - t0 <= RC_N + 2)});
    chk("rc result", {24'h0, smp}, {24'h0, dac_a_code});
    rd(4'h0, 32'h95, 32'hFF);
    rd(4'h6, 32'h1, 32'hFF);
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h80);
    $display("test rc conversion done");
    conv_sample <= 8'h5A;
    w0 = wakes;
    wr(4'h0, 8'h88);
    wr(4'h5, 8'h02);
    cycles(CONV_T + 60);
    chk("abort irq", 32'h0, {31'h0, irq});
    chk("abort wake", 32'h0, wakes - w0);
    chk("abort result", 32'h0, {24'h0, dac_a_code});
    chk("abort state", 32'h1, {30'h0, conv_sampling, cpu_power_down});
    rd(4'h0, 32'h0, 32'h10);
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h80);
    $display("test abort done");
    for (int c = 0; c < 2; c++) begin
      for (cfg = 0; cfg < 8; cfg++) begin
        g = $random(seed);
        if (c == 0) cmp_a_gt <= g;
        else cmp_b_gt <= g;
        wr(4'h3 + c[3:0], 8'h20 | (cfg << 2));
        cycles(4);
        chk("pin", {31'h0, g[cfg[1]]}, {31'h0, pin[c]});
        chk("oe_b", {31'h0, !cfg[0]}, {31'h0, oeb[c]});
        chk("pos sel", {31'h0, cfg[2]}, {31'h0, psel[c]});
        rd(4'h3 + c[3:0], 32'h20 | (cfg << 2) | (g[cfg[1]] << 1), 32'hFE);
      end
      // settling time after enable, with the comparator interrupt still masked
      cycles(1250);
      wr(4'h3 + c[3:0], 8'h3C);
      rd(4'h6, 32'h0, 32'hFFFF_FFF9);
      wr(4'h7, 8'h01 << (c + 1));
      g = {2{!g[1]}};
      if (c == 0) cmp_a_gt <= g;
      else cmp_b_gt <= g;
      cycles(4);
      chk("cmp irq", 32'h1, {31'h0, irq});
      rd(4'h3 + c[3:0], 32'h3D | (g[0] << 1), 32'hFF);
      rd(4'h6, 32'h1 << (c + 1), 32'hFF);
      cycles(2);
      chk("cmp irq clear", 32'h0, {31'h0, irq});
      wr(4'h7, 8'h00);
      g = ~g;
      if (c == 0) cmp_a_gt <= g;
      else cmp_b_gt <= g;
      cycles(4);
      chk("masked irq", 32'h0, {31'h0, irq});
      rd(4'h6, 32'h1 << (c + 1), 32'hFF);
    end
    $display("test comparators done");
    conclude();
  end
endmodule : tb
